/* rtl/scc_pkg.sv */
`default_nettype none

package scc_pkg;

    // =====================================================================
    // register bus
    // =====================================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } scc_bus_req_t;

    // =====================================================================
    // register map
    // =====================================================================
    localparam logic [ADDR_W-1:0] SYSTEM_CLOCK_CONFIG_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] CLOCK_STATUS_OFS        = 8'h1D;

    // =====================================================================
    // clock configuration fields
    // =====================================================================
    localparam int unsigned USB_CLOCK_GATE_BIT   = 3;
    localparam int unsigned DEEP_POWER_SAVE_BIT  = 4;
    localparam int unsigned OSC_FREQ_SELECT_BIT  = 6;
    localparam int unsigned PS2_MODE_IND_BIT     = 7;
    localparam logic [DATA_W-1:0] CONFIG_RW_MASK = 8'hD8;

    localparam logic USB_CLOCK_GATE_RST  = 1'b0;
    localparam logic DEEP_POWER_SAVE_RST = 1'b0;
    localparam logic OSC_FREQ_SELECT_RST = 1'b0;
    localparam logic PS2_MODE_IND_RST    = 1'b0;

    // oscillator select encodings
    localparam logic OSC_SEL_12MHZ = 1'b0;
    localparam logic OSC_SEL_6MHZ  = 1'b1;

    // =====================================================================
    // status fields
    // =====================================================================
    localparam int unsigned REFUSED_BIT      = 0;
    localparam int unsigned USB_MODE_BIT     = 1;
    localparam int unsigned LVR_DISABLED_BIT = 2;
    localparam logic REFUSED_RST  = 1'b0;
    localparam logic USB_MODE_RST = 1'b0;
    localparam logic LVR_EN_RST   = 1'b1;

endpackage : scc_pkg

`default_nettype wire

/* rtl/scc_field.sv */
`timescale 1ns/1ps
`default_nettype none

module scc_field #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // load
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    // stored value
    output var  logic [W-1:0] q
);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= RST;
        end else if (load) begin
            q <= d;
        end
    end

endmodule : scc_field

`default_nettype wire

/* rtl/scc_ctrl.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module scc_ctrl
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // register port
    input  wire scc_pkg::scc_bus_req_t bus_req,
    output var  logic [scc_pkg::DATA_W-1:0] rdata,
    // interface selection from the endpoint status register
    input  wire logic                 usb_interface_select,
    input  wire logic                 ps2_interface_select,
    // clock and power controls
    output var  logic                 usb_clock_gate,
    output var  logic                 deep_power_save,
    output var  logic                 oscillator_frequency_select,
    output var  logic                 ps2_mode_indicator,
    output var  logic                 low_voltage_reset_en,
    output var  logic                 usb_mode
);
    import scc_pkg::*;

    // =====================================================================
    // decode
    // =====================================================================
    wire logic              hit_config;
    wire logic              hit_status;
    wire logic              wr_config;
    wire logic              wr_status;
    wire logic              live_usb_mode;
    wire logic              dps_request;
    wire logic              dps_refused;
    wire logic              next_dps;
    wire logic              refused_clear;
    wire logic              next_refused;
    wire logic [DATA_W-1:0] config_view;
    wire logic [DATA_W-1:0] status_view;
    wire logic [DATA_W-1:0] next_rdata;
    logic                   refused;

    assign hit_config = (bus_req.addr == SYSTEM_CLOCK_CONFIG_OFS);
    assign hit_status = (bus_req.addr == CLOCK_STATUS_OFS);
    assign wr_config  = bus_req.wr & hit_config;
    assign wr_status  = bus_req.wr & hit_status;

    assign live_usb_mode = ~ps2_interface_select & usb_interface_select;

    // =====================================================================
    // deep power save guard
    // =====================================================================
    // the bit is forced low while usb mode holds, so a write that tries to
    // set it is dropped and an already set bit falls back to zero
    assign dps_request = wr_config ? bus_req.wdata[DEEP_POWER_SAVE_BIT] : deep_power_save;
    assign next_dps    = dps_request & ~live_usb_mode;
    assign dps_refused = dps_request & live_usb_mode;

    // sticky refusal flag; a new refusal beats a write-one clear
    assign refused_clear = wr_status & bus_req.wdata[REFUSED_BIT];
    assign next_refused  = dps_refused | (refused & ~refused_clear);

    // =====================================================================
    // fields
    // =====================================================================
    scc_field #(.W(1), .RST(USB_CLOCK_GATE_RST)) u_usb_clock_gate (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (wr_config),
        .d       (bus_req.wdata[USB_CLOCK_GATE_BIT]),
        .q       (usb_clock_gate)
    );

    scc_field #(.W(1), .RST(DEEP_POWER_SAVE_RST)) u_deep_power_save (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (1'b1),
        .d       (next_dps),
        .q       (deep_power_save)
    );

    scc_field #(.W(1), .RST(OSC_FREQ_SELECT_RST)) u_osc_freq_select (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (wr_config),
        .d       (bus_req.wdata[OSC_FREQ_SELECT_BIT]),
        .q       (oscillator_frequency_select)
    );

    // rst_n doubles as power-on reset here
    scc_field #(.W(1), .RST(PS2_MODE_IND_RST)) u_ps2_mode_ind (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (wr_config),
        .d       (bus_req.wdata[PS2_MODE_IND_BIT]),
        .q       (ps2_mode_indicator)
    );

    scc_field #(.W(1), .RST(REFUSED_RST)) u_refused (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (1'b1),
        .d       (next_refused),
        .q       (refused)
    );

    // =====================================================================
    // derived outputs
    // =====================================================================
    // registered from the next value so it tracks the bit without lag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            low_voltage_reset_en <= LVR_EN_RST;
            usb_mode             <= USB_MODE_RST;
        end else begin
            low_voltage_reset_en <= ~next_dps;
            usb_mode             <= live_usb_mode;
        end
    end

    // =====================================================================
    // read path
    // =====================================================================
    // reserved bits are not stored, so they read zero whatever was written
    assign config_view = {ps2_mode_indicator, oscillator_frequency_select, 1'b0,
                          deep_power_save, usb_clock_gate, 3'h0};
    assign status_view = {5'h00, ~low_voltage_reset_en, usb_mode, refused};
    assign next_rdata  = !bus_req.rd ? 8'h00 :
                         hit_config  ? (config_view & CONFIG_RW_MASK) :
                         hit_status  ? status_view : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule : scc_ctrl

`default_nettype wire

/* test/scc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// clock config checker
module scc_monitor
    import scc_pkg::*;
(
    // clock and reset
    input wire logic         ref_clk,
    input wire logic         rst_n,
    // register port
    input wire scc_bus_req_t bus_req,
    input wire logic [7:0]   rdata,
    // selects and controls
    input wire logic         usb_interface_select,
    input wire logic         ps2_interface_select,
    input wire logic         usb_clock_gate,
    input wire logic         deep_power_save,
    input wire logic         oscillator_frequency_select,
    input wire logic         ps2_mode_indicator,
    input wire logic         low_voltage_reset_en,
    input wire logic         usb_mode
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic cfg_wr = bus_req.wr && bus_req.addr == SYSTEM_CLOCK_CONFIG_OFS;
    wire logic cfg_rd = bus_req.rd && bus_req.addr == SYSTEM_CLOCK_CONFIG_OFS;
    chk_lvr_tracks_save: assert property (low_voltage_reset_en == !deep_power_save)
        else $error("lvr enable wrong");
    chk_usb_mode_decode: assert property ($past(rst_n) |->
        usb_mode == $past(!ps2_interface_select && usb_interface_select)) else $error("usb mode");
    chk_save_blocked_usb: assert property (usb_mode |-> !deep_power_save)
        else $error("deep save in usb mode");
    chk_gate_write: assert property (cfg_wr |=> usb_clock_gate == $past(bus_req.wdata[3]))
        else $error("gate write");
    chk_osc_write: assert property (cfg_wr |=>
        oscillator_frequency_select == $past(bus_req.wdata[6])) else $error("osc write");
    chk_ps2_write: assert property (cfg_wr |=>
        ps2_mode_indicator == $past(bus_req.wdata[7])) else $error("ps2 write");
    chk_read_data: assert property (cfg_rd |=> rdata == {$past(ps2_mode_indicator),
        $past(oscillator_frequency_select), 1'b0, $past(deep_power_save),
        $past(usb_clock_gate), 3'h0}) else $error("read data");
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("rdata not idle");
    chk_fields_hold: assert property ($past(rst_n) && !$past(bus_req.wr) |->
        $stable({usb_clock_gate, oscillator_frequency_select, ps2_mode_indicator}))
        else $error("field moved");
    cov_cfg_write: cover property (cfg_wr && bus_req.wdata[4]);
    cov_refused: cover property (cfg_wr && bus_req.wdata[4] && usb_mode);
    cov_usb_rise: cover property ($rose(usb_mode));
endmodule : scc_monitor
bind scc_ctrl scc_monitor mon_u (.ref_clk, .rst_n, .bus_req, .rdata, .usb_interface_select,
    .ps2_interface_select, .usb_clock_gate, .deep_power_save, .oscillator_frequency_select,
    .ps2_mode_indicator, .low_voltage_reset_en, .usb_mode);
`default_nettype wire

/* test/scc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// clock config bench
module scc_ctrl_tb;
    import scc_pkg::*;
    localparam logic [7:0] CFG = SYSTEM_CLOCK_CONFIG_OFS;
    localparam logic [7:0] STS = CLOCK_STATUS_OFS;
    logic ref_clk, rst_n, usb_sel, ps2_sel, gate, dps, osc, ps2i, low_voltage_reset, umode;
    logic [7:0] rdata;
    scc_bus_req_t req;
    int err_total = 0;
    int n_compared = 0;
    // packed view of all controls for one compare
    wire logic [7:0] outs = {2'h0, umode, low_voltage_reset, ps2i, osc, dps, gate};
    scc_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req), .rdata(rdata),
        .usb_interface_select(usb_sel), .ps2_interface_select(ps2_sel), .usb_clock_gate(gate),
        .deep_power_save(dps), .oscillator_frequency_select(osc), .ps2_mode_indicator(ps2i),
        .low_voltage_reset_en(low_voltage_reset), .usb_mode(umode));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one-cycle strobe, then a gap so no signal is driven twice per step
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
        req <= '0;
        #1;
        if (!w) chk(rdata, d);
    endtask : acc
    task automatic sel(input logic u, input logic p, input logic [7:0] exp);
        @(posedge ref_clk);
        usb_sel <= u;
        ps2_sel <= p;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(outs, exp);
    endtask : sel
    task automatic conclude;
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        rst_n = 1'b0;
        usb_sel = 1'b0;
        ps2_sel = 1'b0;
        req = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk(outs, 8'h10);
        acc(1'b0, CFG, 8'h00);
        for (int i = 3; i < 8; i++) begin
            if (i != 5) begin
                acc(1'b1, CFG, 8'h01 << i);
                acc(1'b0, CFG, 8'h01 << i);
            end
        end
        acc(1'b1, CFG, 8'hD8);
        chk(outs, 8'h0F);
        acc(1'b1, 8'h20, 8'hFF);
        acc(1'b0, 8'h20, 8'h00);
        acc(1'b0, CFG, 8'hD8);
        sel(1'b1, 1'b0, 8'h3D);
        acc(1'b1, CFG, 8'h10);
        chk(outs, 8'h30);
        acc(1'b0, STS, 8'h03);
        acc(1'b1, STS, 8'h01);
        acc(1'b0, STS, 8'h02);
        sel(1'b1, 1'b1, 8'h10);
        acc(1'b1, CFG, 8'hD8);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk(outs, 8'h10);
        acc(1'b0, CFG, 8'h00);
        conclude();
    end
endmodule : scc_ctrl_tb
`default_nettype wire
